// >>> etc_top.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module etc_top #(
  parameter int PAGES   = 16,
  parameter int LPS     = 4,
  parameter int VA_BITS = 48
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic                          irq,
  output logic                          map_req,
  output logic      [31:0]              map_page,
  input  wire logic                     map_ack,
  input  wire etc_pkg::etc_map_rsp_t    map_rsp,
  input  wire logic [PAGES-1:0]         busy_mask,
  input  wire logic                     trk_ack,
  input  wire logic [$clog2(PAGES)-1:0] trk_ack_page,
  input  wire logic [$clog2(LPS)-1:0]   trk_ack_lp
);
  localparam int IW    = $clog2(PAGES);
  localparam int IRQ_W = etc_pkg::IRQ_BITS;

  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_LOOKUP} etc_state_t;

  etc_state_t            st_r;
  logic [31:0]           leaf_r;
  logic [63:0]           opnd_r;
  logic [31:0]           seglim_r;
  logic [31:0]           pc_base_r;
  logic [31:0]           pc_pages_r;
  logic [1:0]            cpl_r;
  logic                  mode64_r;
  logic                  prot_r;
  logic [31:0]           flags_r;
  logic [31:0]           rc_r;
  logic [1:0]            fault_r;
  logic [15:0]           err_r;
  logic [63:0]           faddr_r;
  logic                  done_r;
  logic [IRQ_W-1:0]      irq_stat_r;
  logic [IRQ_W-1:0]      irq_en_r;
  logic [31:0]           prdata_r;
  logic                  wr_en;
  logic                  rd_setup;
  logic                  go;
  logic                  canon;
  logic                  seg_over;
  logic [31:0]           rel_page;
  logic                  in_cache;
  logic                  trk_active;
  logic                  finish;
  etc_pkg::etc_result_t  early;
  etc_pkg::etc_result_t  late;
  etc_pkg::etc_result_t  res;
  logic [IRQ_W-1:0]      irq_set;
  logic                  map_ok;

  initial
  begin
    if (VA_BITS < 44 || VA_BITS > 63)
      $error("etc_top supports 44 to 63 virtual address bits");
  end

  // Zero wait states; read data is captured in the setup cycle
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign prdata   = prdata_r;
  assign go = wr_en && paddr == etc_pkg::ADDR_CTRL && pwdata[etc_pkg::CTRL_GO]
              && st_r == ST_IDLE;

  // Unmapped addresses answer with an error; a read of the write-only clear register does not
  always_comb
  begin
    unique case (paddr)
      etc_pkg::ADDR_CTRL, etc_pkg::ADDR_LEAF, etc_pkg::ADDR_OPND_LO,
      etc_pkg::ADDR_OPND_HI, etc_pkg::ADDR_SEGLIM, etc_pkg::ADDR_RETCODE,
      etc_pkg::ADDR_FLAGS, etc_pkg::ADDR_STATUS, etc_pkg::ADDR_FADDR_LO,
      etc_pkg::ADDR_FADDR_HI, etc_pkg::ADDR_IRQ_STAT, etc_pkg::ADDR_IRQ_CLR,
      etc_pkg::ADDR_IRQ_EN, etc_pkg::ADDR_PC_BASE, etc_pkg::ADDR_PC_PAGES:
        pslverr = 1'b0;
      default:
        pslverr = psel && penable;
    endcase
  end

  // Operand setup; frozen while a leaf runs so checks see stable inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      leaf_r     <= '0;
      opnd_r     <= '0;
      seglim_r   <= etc_pkg::SEGLIM_RESET;
      pc_base_r  <= '0;
      pc_pages_r <= '0;
      cpl_r      <= '0;
      mode64_r   <= 1'b0;
      prot_r     <= 1'b0;
    end
    else if (wr_en && st_r == ST_IDLE)
    begin
      unique case (paddr)
        etc_pkg::ADDR_CTRL:
        begin
          cpl_r    <= pwdata[etc_pkg::CTRL_CPL_LO +: 2];
          mode64_r <= pwdata[etc_pkg::CTRL_MODE64];
          prot_r   <= pwdata[etc_pkg::CTRL_PROT];
        end
        etc_pkg::ADDR_LEAF:     leaf_r            <= pwdata;
        etc_pkg::ADDR_OPND_LO:  opnd_r[31:0]      <= pwdata;
        etc_pkg::ADDR_OPND_HI:  opnd_r[63:32]     <= pwdata;
        etc_pkg::ADDR_SEGLIM:   seglim_r          <= pwdata;
        etc_pkg::ADDR_PC_BASE:  pc_base_r         <= pwdata;
        etc_pkg::ADDR_PC_PAGES: pc_pages_r        <= pwdata;
        default:                leaf_r            <= leaf_r;
      endcase
    end
  end

  // Address qualification of the operand pointer
  assign canon    = &opnd_r[63:VA_BITS-1] || ~|opnd_r[63:VA_BITS-1];
  assign seg_over = ({1'b0, opnd_r[31:0]} + {21'h0, etc_pkg::PAGE_OFS_MAX})
                    > {1'b0, seglim_r};
  assign rel_page = opnd_r[43:12] - pc_base_r;
  assign in_cache = ~|opnd_r[63:44] && rel_page < pc_pages_r
                    && rel_page < 32'(PAGES);
  assign map_page = opnd_r[43:12];
  assign map_req  = st_r == ST_LOOKUP;
  assign map_ok   = map_req && map_ack;

  // Checks that need no lookup, in architectural priority order
  always_comb
  begin
    early       = '0;
    early.err   = etc_pkg::GP_ERR_ZERO;
    if (leaf_r != etc_pkg::TRACK_LEAF_CODE)
      early.fault = etc_pkg::FLT_GP;
    else if (cpl_r != 2'h0)
      early.fault = etc_pkg::FLT_UD;
    else if (mode64_r && !canon)
      early.fault = etc_pkg::FLT_GP;
    else if (!mode64_r && prot_r && seg_over)
      early.fault = etc_pkg::FLT_GP;
    else if (opnd_r[11:0] != 12'h000)
      early.fault = etc_pkg::FLT_GP;
    else if (!in_cache)
    begin
      early.fault = etc_pkg::FLT_PF;
      early.err   = etc_pkg::PF_ERR_NOT_CACHE;
    end
  end

  // Checks on the map answer and the tracking indicator
  always_comb
  begin
    late     = '0;
    late.err = etc_pkg::GP_ERR_ZERO;
    if (map_rsp.xlat_fault)
    begin
      late.fault = etc_pkg::FLT_PF;
      late.err   = map_rsp.xlat_err;
    end
    else if (busy_mask[rel_page[IW-1:0]])
      late.fault = etc_pkg::FLT_GP;
    else if (!map_rsp.entry_valid)
    begin
      late.fault = etc_pkg::FLT_PF;
      late.err   = etc_pkg::PF_ERR_NOT_CACHE;
    end
    else if (map_rsp.page_type != etc_pkg::CONTROL_PAGE_TYPE)
    begin
      late.fault = etc_pkg::FLT_PF;
      late.err   = etc_pkg::PF_ERR_NOT_CACHE;
    end
    else if (trk_active)
    begin
      late.rc = etc_pkg::PREV_TRK_INCMPL;
      late.zf = 1'b1;
    end
    else
    begin
      late.rc    = etc_pkg::RC_OK;
      late.start = 1'b1;
    end
  end

  assign finish = (st_r == ST_CHECK && early.fault != etc_pkg::FLT_NONE) || map_ok;
  assign res    = (st_r == ST_CHECK) ? early : late;

  // Sequencer: check, then wait for the map lookup as long as it takes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= ST_IDLE;
    else
    begin
      unique case (st_r)
        ST_IDLE:   if (go) st_r <= ST_CHECK;
        ST_CHECK:  st_r <= (early.fault != etc_pkg::FLT_NONE) ? ST_IDLE : ST_LOOKUP;
        ST_LOOKUP: if (map_ack) st_r <= ST_IDLE;
        default:   st_r <= ST_IDLE; // Unused code falls back to idle
      endcase
    end
  end

  // Result capture; a fault leaves the return code and flags alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rc_r    <= '0;
      fault_r <= etc_pkg::FLT_NONE;
      err_r   <= '0;
      faddr_r <= '0;
      done_r  <= 1'b0;
    end
    else
    begin
      done_r <= finish;
      if (finish)
      begin
        fault_r <= res.fault;
        err_r   <= res.err;
        faddr_r <= (res.fault == etc_pkg::FLT_PF) ? opnd_r : 64'h0;
        if (res.fault == etc_pkg::FLT_NONE)
          rc_r <= res.rc;
      end
    end
  end

  // Flags: hardware completion wins over a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_r <= etc_pkg::FLAGS_RESET;
    else if (finish && res.fault == etc_pkg::FLT_NONE)
    begin
      flags_r[etc_pkg::FLG_CF] <= 1'b0;
      flags_r[etc_pkg::FLG_PF] <= 1'b0;
      flags_r[etc_pkg::FLG_AF] <= 1'b0;
      flags_r[etc_pkg::FLG_OF] <= 1'b0;
      flags_r[etc_pkg::FLG_SF] <= 1'b0;
      flags_r[etc_pkg::FLG_ZF] <= res.zf;
    end
    else if (wr_en && paddr == etc_pkg::ADDR_FLAGS)
      flags_r <= pwdata;
  end

  etc_track_table #(
    .PAGES (PAGES),
    .LPS   (LPS)
  ) u_track (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (map_ok && late.start),
    .start_idx (rel_page[IW-1:0]),
    .ack       (trk_ack),
    .ack_idx   (trk_ack_page),
    .ack_lp    (trk_ack_lp),
    .rd_idx    (rel_page[IW-1:0]),
    .rd_active (trk_active)
  );

  // Sticky events; a new event wins over a clear in the same cycle
  assign irq_set[etc_pkg::IRQ_DONE]  = finish && res.fault == etc_pkg::FLT_NONE;
  assign irq_set[etc_pkg::IRQ_FAULT] = finish && res.fault != etc_pkg::FLT_NONE;
  assign irq_set[etc_pkg::IRQ_INCMP] = finish && res.fault == etc_pkg::FLT_NONE && res.zf;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_r <= '0;
      irq_en_r   <= '0;
    end
    else
    begin
      if (wr_en && paddr == etc_pkg::ADDR_IRQ_CLR)
        irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
      if (wr_en && paddr == etc_pkg::ADDR_IRQ_EN)
        irq_en_r <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // Read mux, registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= '0;
    else if (rd_setup)
    begin
      unique case (paddr)
        etc_pkg::ADDR_CTRL:
          prdata_r <= {23'h0, st_r != ST_IDLE, 3'h0, prot_r, mode64_r, cpl_r, 1'b0};
        etc_pkg::ADDR_LEAF:     prdata_r <= leaf_r;
        etc_pkg::ADDR_OPND_LO:  prdata_r <= opnd_r[31:0];
        etc_pkg::ADDR_OPND_HI:  prdata_r <= opnd_r[63:32];
        etc_pkg::ADDR_SEGLIM:   prdata_r <= seglim_r;
        etc_pkg::ADDR_RETCODE:  prdata_r <= rc_r;
        etc_pkg::ADDR_FLAGS:    prdata_r <= flags_r;
        etc_pkg::ADDR_STATUS:   prdata_r <= {err_r, 12'h0, trk_active, fault_r, st_r != ST_IDLE};
        etc_pkg::ADDR_FADDR_LO: prdata_r <= faddr_r[31:0];
        etc_pkg::ADDR_FADDR_HI: prdata_r <= faddr_r[63:32];
        etc_pkg::ADDR_IRQ_STAT: prdata_r <= {29'h0, irq_stat_r};
        etc_pkg::ADDR_IRQ_EN:   prdata_r <= {29'h0, irq_en_r};
        etc_pkg::ADDR_PC_BASE:  prdata_r <= pc_base_r;
        etc_pkg::ADDR_PC_PAGES: prdata_r <= pc_pages_r;
        default:                prdata_r <= '0;
      endcase
    end
  end

  // Checks on outcomes, sampled one edge after capture
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_leaf;
    done_r && leaf_r != etc_pkg::TRACK_LEAF_CODE |-> fault_r == etc_pkg::FLT_GP;
  endproperty
  a_leaf: assert property (p_leaf) else $error("wrong leaf not refused");

  property p_cpl;
    done_r && leaf_r == etc_pkg::TRACK_LEAF_CODE && cpl_r != 2'h0
      |-> fault_r == etc_pkg::FLT_UD;
  endproperty
  a_cpl: assert property (p_cpl) else $error("nonzero privilege not refused");

  property p_align;
    done_r && opnd_r[11:0] != 12'h000 |-> fault_r != etc_pkg::FLT_NONE;
  endproperty
  a_align: assert property (p_align) else $error("unaligned pointer accepted");

  property p_range;
    go ##1 (early.fault == etc_pkg::FLT_PF) |=> done_r && faddr_r == opnd_r
      && err_r == etc_pkg::PF_ERR_NOT_CACHE;
  endproperty
  a_range: assert property (p_range) else $error("out of cache pointer mishandled");

  property p_busy;
    map_ok && !map_rsp.xlat_fault && busy_mask[rel_page[IW-1:0]]
      |=> fault_r == etc_pkg::FLT_GP && err_r == 16'h0000;
  endproperty
  a_busy: assert property (p_busy) else $error("concurrent use not refused");

  property p_invalid;
    map_ok && !map_rsp.xlat_fault && !busy_mask[rel_page[IW-1:0]]
      && !map_rsp.entry_valid |=> fault_r == etc_pkg::FLT_PF && faddr_r == opnd_r;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid entry accepted");

  property p_type;
    done_r && fault_r == etc_pkg::FLT_NONE
      |-> $past(map_rsp.page_type) == etc_pkg::CONTROL_PAGE_TYPE;
  endproperty
  a_type: assert property (p_type) else $error("wrong page type accepted");

  property p_incmpl;
    done_r && fault_r == etc_pkg::FLT_NONE
      |-> flags_r[etc_pkg::FLG_ZF] == (rc_r == etc_pkg::PREV_TRK_INCMPL);
  endproperty
  a_incmpl: assert property (p_incmpl) else $error("zero flag and code disagree");

  property p_flags;
    done_r && fault_r == etc_pkg::FLT_NONE |-> !flags_r[etc_pkg::FLG_CF]
      && !flags_r[etc_pkg::FLG_PF] && !flags_r[etc_pkg::FLG_AF]
      && !flags_r[etc_pkg::FLG_OF] && !flags_r[etc_pkg::FLG_SF];
  endproperty
  a_flags: assert property (p_flags) else $error("arithmetic flags not cleared");

  property p_canon;
    done_r && mode64_r && !canon |-> fault_r != etc_pkg::FLT_NONE;
  endproperty
  a_canon: assert property (p_canon) else $error("non canonical pointer accepted");

  property p_seg;
    done_r && !mode64_r && prot_r && seg_over |-> fault_r != etc_pkg::FLT_NONE;
  endproperty
  a_seg: assert property (p_seg) else $error("segment overrun accepted");

  property p_xlat;
    map_ok && map_rsp.xlat_fault |=> fault_r == etc_pkg::FLT_PF
      && err_r == $past(map_rsp.xlat_err);
  endproperty
  a_xlat: assert property (p_xlat) else $error("translation fault lost");

  property p_track;
    map_ok && late.start && !trk_ack |=> trk_active;
  endproperty
  a_track: assert property (p_track) else $error("indicator not set on start");

  c_success: cover property (done_r && fault_r == etc_pkg::FLT_NONE && rc_r == etc_pkg::RC_OK);
  c_incmpl:  cover property (done_r && rc_r == etc_pkg::PREV_TRK_INCMPL);
  c_pf:      cover property (done_r && fault_r == etc_pkg::FLT_PF);
  c_irq:     cover property ($rose(irq));
endmodule

// >>> etc_pkg.sv
package etc_pkg;
  // Summary of operation
  // - Leaf code 0x0C selects tracking activation
  // - Only privilege level zero may run it
  // - Unaligned operand pointer gives protection fault
  // - Pointer outside page cache gives page fault
  // - Concurrent tracking use gives protection fault
  // - Invalid map entry gives page fault
  // - Non control page type gives page fault
  // - Pending tracking sets zero flag, incomplete code
  // - Completion clears carry, parity, aux, overflow, sign
  // - Non canonical address in 64-bit mode faults
  // - Protected mode segment limit overrun faults
  // - Translation fault becomes page fault with code

  // APB register byte offsets
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_LEAF    = 12'h004;
  localparam logic [11:0] ADDR_OPND_LO = 12'h008;
  localparam logic [11:0] ADDR_OPND_HI = 12'h00C;
  localparam logic [11:0] ADDR_SEGLIM  = 12'h010;
  localparam logic [11:0] ADDR_RETCODE = 12'h014;
  localparam logic [11:0] ADDR_FLAGS   = 12'h018;
  localparam logic [11:0] ADDR_STATUS  = 12'h01C;
  localparam logic [11:0] ADDR_FADDR_LO = 12'h020;
  localparam logic [11:0] ADDR_FADDR_HI = 12'h024;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h028;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h02C;
  localparam logic [11:0] ADDR_IRQ_EN  = 12'h030;
  localparam logic [11:0] ADDR_PC_BASE = 12'h034;
  localparam logic [11:0] ADDR_PC_PAGES = 12'h038;

  // Control register fields
  localparam int CTRL_GO     = 0;
  localparam int CTRL_CPL_LO = 1;
  localparam int CTRL_MODE64 = 3;
  localparam int CTRL_PROT   = 4;
  localparam int CTRL_BUSY   = 8;

  // Flags register bit positions
  localparam int FLG_CF = 0;
  localparam int FLG_PF = 2;
  localparam int FLG_AF = 4;
  localparam int FLG_ZF = 6;
  localparam int FLG_SF = 7;
  localparam int FLG_OF = 11;

  // Interrupt status bits
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_INCMP = 2;
  localparam int IRQ_BITS  = 3;

  // Fault kinds
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_GP   = 2'h1;
  localparam logic [1:0] FLT_PF   = 2'h2;
  localparam logic [1:0] FLT_UD   = 2'h3;

  // Codes and reset values
  localparam logic [31:0] TRACK_LEAF_CODE = 32'h0000_000C;
  localparam logic [31:0] PREV_TRK_INCMPL = 32'h0000_000B;
  localparam logic [31:0] RC_OK           = 32'h0000_0000;
  localparam logic [7:0]  CONTROL_PAGE_TYPE = 8'h00;
  localparam logic [15:0] PF_ERR_NOT_CACHE = 16'h0001;
  localparam logic [15:0] GP_ERR_ZERO     = 16'h0000;
  localparam logic [31:0] FLAGS_RESET     = 32'h0000_0002;
  localparam logic [31:0] SEGLIM_RESET    = 32'hFFFF_FFFF;
  localparam logic [11:0] PAGE_OFS_MAX    = 12'hFFF;

  // Answer from the page cache map lookup
  typedef struct packed {
    logic        entry_valid;
    logic [7:0]  page_type;
    logic        xlat_fault;
    logic [15:0] xlat_err;
  } etc_map_rsp_t;

  // Outcome of one check stage
  typedef struct packed {
    logic [1:0]  fault;
    logic [15:0] err;
    logic [31:0] rc;
    logic        zf;
    logic        start;
  } etc_result_t;
endpackage

// >>> etc_track_table.sv
`timescale 1ns/1ns
module etc_track_table #(
  parameter int PAGES = 16,
  parameter int LPS   = 4
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     start,
  input  wire logic [$clog2(PAGES)-1:0] start_idx,
  input  wire logic                     ack,
  input  wire logic [$clog2(PAGES)-1:0] ack_idx,
  input  wire logic [$clog2(LPS)-1:0]   ack_lp,
  input  wire logic [$clog2(PAGES)-1:0] rd_idx,
  output logic                          rd_active
);
  logic [LPS-1:0] pending_r [PAGES];

  initial
  begin
    if (PAGES < 2 || LPS < 2)
      $error("etc_track_table needs at least two pages and two processors");
  end

  // Each processor retires its bit; a fresh start wins over a retire
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < PAGES; i++)
        pending_r[i] <= '0;
    end
    else
    begin
      if (ack && !(start && start_idx == ack_idx))
        pending_r[ack_idx][ack_lp] <= 1'b0;
      if (start)
        pending_r[start_idx] <= '1;
    end
  end

  // Indicator stays set until every processor has retired
  assign rd_active = |pending_r[rd_idx];
endmodule

// >>> tb_enclave_tracking_check.sv
`timescale 1ns/1ns
module tb_enclave_tracking_check;
  localparam logic [31:0] LEAF    = etc_pkg::TRACK_LEAF_CODE;
  localparam logic [31:0] PG3     = 32'h0010_3000;
  localparam logic [31:0] PG5     = 32'h0010_5000;
  localparam logic [31:0] PG8     = 32'h0010_8000;
  localparam logic [31:0] FLG_SET = 32'h0000_08D7;
  localparam etc_pkg::etc_map_rsp_t RSP_OK = '{1'b1, etc_pkg::CONTROL_PAGE_TYPE, 1'b0, 16'h0000};
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic                  map_req, map_ack, trk_ack, last_err, irq_en;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, map_page, last_rc, q, exp_page;
  logic [15:0]           busy_mask;
  logic [3:0]            trk_ack_page;
  logic [1:0]            trk_ack_lp;
  int                    fails, comparisons, map_dly, wcnt;
  etc_pkg::etc_map_rsp_t rsp_cfg, map_rsp;

  etc_top u_etc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .map_req(map_req), .map_page(map_page), .map_ack(map_ack),
    .map_rsp(map_rsp), .busy_mask(busy_mask), .trk_ack(trk_ack), .trk_ack_page(trk_ack_page),
    .trk_ack_lp(trk_ack_lp));

  // Map answer only valid with ack; inverted otherwise so stale data cannot pass
  assign map_rsp = map_ack ? rsp_cfg : etc_pkg::etc_map_rsp_t'(~rsp_cfg);

  // Map responder with programmable latency
  always @(posedge pclk)
    if (map_req === 1'b1 && !map_ack)
    begin
      if (wcnt >= map_dly)
      begin
        check("map page", exp_page, map_page);
        map_ack <= 1'b1;
        wcnt <= 0;
      end
      else
        wcnt <= wcnt + 1;
    end
    else
      map_ack <= 1'b0;

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; idle cycle after it so strobes never toggle twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  // Full leaf run, then every result register judged against the outcome
  task automatic run(input logic [31:0] leaf, input logic [31:0] ctl, input logic [31:0] hi,
                     input logic [31:0] lo, input logic [1:0] kind, input logic [15:0] err,
                     input logic [31:0] rc, input logic zf);
    int n;
    wr(etc_pkg::ADDR_FLAGS, FLG_SET);
    wr(etc_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
    wr(etc_pkg::ADDR_LEAF, leaf);
    wr(etc_pkg::ADDR_OPND_LO, lo);
    wr(etc_pkg::ADDR_OPND_HI, hi);
    exp_page = {hi[11:0], lo[31:12]};
    wr(etc_pkg::ADDR_CTRL, ctl | 32'h0000_0001);
    n = 0;
    q = 32'h0000_0001;
    while (q[0] !== 1'b0 && n < 40)
    begin
      apb(1'b0, etc_pkg::ADDR_STATUS, 32'h0000_0000, q);
      n++;
    end
    check("busy", 32'h0000_0000, {31'h0, q[0]});
    check("fault kind", {30'h0, kind}, {30'h0, q[2:1]});
    if (kind != etc_pkg::FLT_UD)
      check("error code", {16'h0, err}, {16'h0, q[31:16]});
    if (kind == etc_pkg::FLT_NONE)
    begin
      check("indicator", 32'h0000_0001, {31'h0, q[3]});
      last_rc = rc;
    end
    apb(1'b0, etc_pkg::ADDR_RETCODE, 32'h0000_0000, q);
    check("return code", last_rc, q);
    apb(1'b0, etc_pkg::ADDR_FLAGS, 32'h0000_0000, q);
    check("flags", (kind == etc_pkg::FLT_NONE) ?
          (32'h0000_0002 | (32'(zf) << etc_pkg::FLG_ZF)) : FLG_SET, q);
    apb(1'b0, etc_pkg::ADDR_FADDR_LO, 32'h0000_0000, q);
    check("fault addr lo", (kind == etc_pkg::FLT_PF) ? lo : 32'h0000_0000, q);
    apb(1'b0, etc_pkg::ADDR_FADDR_HI, 32'h0000_0000, q);
    check("fault addr hi", (kind == etc_pkg::FLT_PF) ? hi : 32'h0000_0000, q);
    apb(1'b0, etc_pkg::ADDR_IRQ_STAT, 32'h0000_0000, q);
    check("irq status", (kind != etc_pkg::FLT_NONE) ? 32'h0000_0002 :
          (zf ? 32'h0000_0005 : 32'h0000_0001), q);
    check("irq line", {31'h0, irq_en}, {31'h0, irq});
  endtask

  task automatic lp_done(input logic [1:0] lp);
    trk_ack <= 1'b1;
    trk_ack_page <= 4'h3;
    trk_ack_lp <= lp;
    @(posedge pclk);
    trk_ack <= 1'b0;
    @(posedge pclk);
  endtask

  // Reset values and an unmapped access
  task automatic t_reset();
    check("irq after reset", 32'h0000_0000, {31'h0, irq});
    apb(1'b0, etc_pkg::ADDR_FLAGS, 32'h0000_0000, q);
    check("flags reset", etc_pkg::FLAGS_RESET, q);
    apb(1'b0, etc_pkg::ADDR_SEGLIM, 32'h0000_0000, q);
    check("seglim reset", etc_pkg::SEGLIM_RESET, q);
    apb(1'b0, 12'h0FC, 32'h0000_0000, q);
    check("unmapped data", 32'h0000_0000, q);
    check("unmapped err", 32'h0000_0001, {31'h0, last_err});
    wr(etc_pkg::ADDR_PC_BASE, 32'h0000_0100);
    wr(etc_pkg::ADDR_PC_PAGES, 32'h0000_0008);
    wr(etc_pkg::ADDR_IRQ_EN, 32'h0000_0007);
  endtask

  // Start, repeat while pending, then finish every processor and start again
  task automatic t_track();
    run(LEAF, 0, 0, PG3, etc_pkg::FLT_NONE, 0, etc_pkg::RC_OK, 1'b0);
    run(LEAF, 0, 0, PG3, etc_pkg::FLT_NONE, 0, etc_pkg::PREV_TRK_INCMPL, 1'b1);
    for (int i = 0; i < 3; i++)
      lp_done(2'(i));
    run(LEAF, 0, 0, PG3, etc_pkg::FLT_NONE, 0, etc_pkg::PREV_TRK_INCMPL, 1'b1);
    lp_done(2'h3);
    run(LEAF, 0, 0, PG3, etc_pkg::FLT_NONE, 0, etc_pkg::RC_OK, 1'b0);
  endtask

  // Faults found before the map is asked
  task automatic t_early();
    run(32'h0000_000B, 0, 0, PG3, etc_pkg::FLT_GP, 0, 0, 0);
    run(LEAF, 32'h0000_0006, 0, PG3, etc_pkg::FLT_UD, 0, 0, 0);
    run(LEAF, 0, 0, PG3 | 32'h0000_0004, etc_pkg::FLT_GP, 0, 0, 0);
    run(LEAF, 0, 0, PG8, etc_pkg::FLT_PF, etc_pkg::PF_ERR_NOT_CACHE, 0, 0);
    run(LEAF, 32'h0000_0008, 32'h0000_8000, PG3, etc_pkg::FLT_GP, 0, 0, 0);
    wr(etc_pkg::ADDR_SEGLIM, 32'h0010_3800);
    run(LEAF, 32'h0000_0010, 0, PG3, etc_pkg::FLT_GP, 0, 0, 0);
    wr(etc_pkg::ADDR_SEGLIM, etc_pkg::SEGLIM_RESET);
  endtask

  // Faults reported by a slow map answer
  task automatic t_map();
    map_dly <= 3;
    rsp_cfg <= '{1'b1, etc_pkg::CONTROL_PAGE_TYPE, 1'b1, 16'h0006};
    run(LEAF, 0, 0, PG5, etc_pkg::FLT_PF, 16'h0006, 0, 0);
    rsp_cfg <= RSP_OK;
    busy_mask <= 16'h0020;
    run(LEAF, 0, 0, PG5, etc_pkg::FLT_GP, 0, 0, 0);
    busy_mask <= 16'h0000;
    rsp_cfg <= '{1'b0, etc_pkg::CONTROL_PAGE_TYPE, 1'b0, 16'h0000};
    run(LEAF, 0, 0, PG5, etc_pkg::FLT_PF, etc_pkg::PF_ERR_NOT_CACHE, 0, 0);
    rsp_cfg <= '{1'b1, 8'h01, 1'b0, 16'h0000};
    run(LEAF, 0, 0, PG5, etc_pkg::FLT_PF, etc_pkg::PF_ERR_NOT_CACHE, 0, 0);
    rsp_cfg <= RSP_OK;
    map_dly <= 0;
  endtask

  // Masked event stays sticky, line follows the enable, clear drops it
  task automatic t_irq();
    wr(etc_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    irq_en = 1'b0;
    run(32'h0000_000B, 0, 0, PG3, etc_pkg::FLT_GP, 0, 0, 0);
    wr(etc_pkg::ADDR_IRQ_EN, 32'h0000_0002);
    check("irq enabled", 32'h0000_0001, {31'h0, irq});
    wr(etc_pkg::ADDR_IRQ_CLR, 32'h0000_0002);
    check("irq cleared", 32'h0000_0000, {31'h0, irq});
    apb(1'b0, etc_pkg::ADDR_IRQ_STAT, 32'h0000_0000, q);
    check("irq status cleared", 32'h0000_0000, q);
  endtask

  // Bench cannot run near this long; a hang ends here
  initial
  begin
    #1_000_000;
    fails++;
    summarize();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    map_ack = 1'b0;
    rsp_cfg = RSP_OK;
    busy_mask = 16'h0000;
    trk_ack = 1'b0;
    trk_ack_page = 4'h0;
    trk_ack_lp = 2'h0;
    fails = 0;
    comparisons = 0;
    map_dly = 0;
    wcnt = 0;
    irq_en = 1'b1;
    last_rc = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_track();
    t_early();
    t_map();
    t_irq();
    summarize();
  end
endmodule
